// file: test_vectored_interrupt_unit.sv
// self-checking bench: pins, core strobes and register port against queued expectations
`timescale 1ns/1ps
module test_vectored_interrupt_unit
  import viu_pkg::*;
;
  logic        i_core_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_reset_pin_n = 1'b1;
  logic        i_nonmaskable_pin = 1'b0;
  logic        i_shared_lowlevel_irq_pin_n = 1'b1;
  logic        i_timer_ovf = 1'b0;
  logic        i_uart_rx_req = 1'b0;
  logic        i_uart_tx_req = 1'b0;
  logic        i_instr_done = 1'b0;
  logic        i_return_from_irq = 1'b0;
  logic        i_ret = 1'b0;
  logic [15:0] i_pc = 16'h0000;
  logic [7:0]  i_addr = 8'h00;
  logic [15:0] i_wr_data = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        mem_slow = 1'b0;
  logic [3:0]  xp = 4'h0;
  logic [2:0]  pol;
  logic        rd_seen = 1'b0;
  logic [31:0] rd_note;
  logic [15:0] exp_pc[$];
  logic [31:0] exp_rd[$];
  int          failures = 0;
  int          n_tests = 0;
  wire logic        i_mem_ack, o_mem_req, o_mem_we, o_mem_byte, o_pc_load, o_core_hold;
  wire logic [7:0]  i_mem_rdata;
  wire logic [15:0] o_rd_data, o_mem_addr, o_mem_wdata, o_new_pc;

  always #10 i_core_clk = ~i_core_clk;

  viu_unit dut (.i_core_clk, .i_reset, .i_reset_pin_n, .i_nonmaskable_pin,
    .i_edge_irq_pin_a(xp[0]), .i_edge_irq_pin_b(xp[1]), .i_edge_irq_pin_c(xp[2]),
    .i_shared_lowlevel_irq_pin_n, .i_capture_irq_pin(xp[3]), .i_timer_ovf,
    .i_uart_rx_req, .i_uart_tx_req, .i_instr_done, .i_return_from_irq, .i_ret, .i_pc,
    .i_mem_ack, .i_mem_rdata, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
    .o_mem_req, .o_mem_we, .o_mem_byte, .o_mem_addr, .o_mem_wdata, .o_pc_load,
    .o_new_pc, .o_core_hold);

  viu_mem_model mem (.i_core_clk, .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_slow(mem_slow),
    .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  function automatic logic [15:0] vecw(input int r);
    return {8'h80 + 8'(r), 8'h10 + 8'(r)};
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  // only the bits under the mask are compared
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_rd.push_back({m, e & m});
    @(posedge i_core_clk);
    i_rd <= 1'b0;
  endtask

  // k: 0 instruction end, 1 interrupt return, 2 plain return
  task automatic core_pulse(input int k, input logic [15:0] p);
    while (o_core_hold !== 1'b0)
      @(negedge i_core_clk);
    @(posedge i_core_clk);
    i_instr_done <= (k == 0);
    i_return_from_irq <= (k == 1);
    i_ret <= (k == 2);
    i_pc <= p;
    mem_slow <= 1'($urandom);
    @(posedge i_core_clk);
    {i_instr_done, i_return_from_irq, i_ret} <= 3'b000;
  endtask

  task automatic settle();
    int n;
    n = 0;
    while ((exp_pc.size() > 0 || o_core_hold !== 1'b0) && n < 300)
    begin
      @(negedge i_core_clk);
      n++;
    end
    chk("settle", 16'h0000, 16'(n >= 300));
    repeat (2) @(negedge i_core_clk);
  endtask

  // drive pin i to its idle level, clear flag b, then make the trigger
  task automatic trig(input int i, input int b, input logic lv);
    xp[i] <= lv;
    cyc(6);
    wr_reg(ADDR_PENDING, ~(16'h0001 << b));
    rd_reg(ADDR_PENDING, 16'h0001 << b, 16'h0000);
    xp[i] <= ~lv;
    cyc(6);
    rd_reg(ADDR_PENDING, 16'h0001 << b, 16'h0001 << b);
  endtask

  ////////////////////////////////////////////////////////////
  always @(negedge i_core_clk)
  begin
    if (rd_seen)
    begin
      rd_note = exp_rd.pop_front();
      chk("rd_data", rd_note[15:0], o_rd_data & rd_note[31:16]);
    end
    rd_seen = i_rd;
    // stack pushes are word writes, vector and stack fetches are byte reads
    if (o_mem_req === 1'b1)
      chk("mem_byte", 16'(!o_mem_we), 16'(o_mem_byte));
    if (o_pc_load === 1'b1)
      chk("new_pc", exp_pc.size() > 0 ? exp_pc.pop_front() : 16'hxxxx, o_new_pc);
  end

  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    failures++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h0c7d6b59));
    exp_pc.push_back(vecw(RANK_RESET));
    cyc(6);
    i_reset <= 1'b0;
    settle();
    wr_reg(ADDR_UART, 16'h0000);
    wr_reg(ADDR_ENABLE, 16'h00ff);
    rd_reg(ADDR_ENABLE, 16'hffff, 16'h00fd);
    wr_reg(8'h20, 16'hffff);
    rd_reg(8'h20, 16'hffff, 16'h0000);
    wr_reg(ADDR_ENABLE, 16'h0000);
    $display("test registers done");
    pol = 3'($urandom);
    wr_reg(ADDR_POLARITY, {13'h0000, pol});
    rd_reg(ADDR_POLARITY, 16'h0007, {13'h0000, pol});
    for (int i = 0; i < NEDGE; i++)
      trig(i, RANK_EDGE_A + i, ~pol[i]);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(ADDR_CAPTURE, 16'(m));
      trig(3, RANK_CAPTURE, m[0]);
    end
    $display("test triggers done");
    @(posedge i_core_clk) i_timer_ovf <= 1'b1;
    @(posedge i_core_clk) i_timer_ovf <= 1'b0;
    @(posedge i_core_clk) i_nonmaskable_pin <= 1'b1;
    cyc(6);
    wr_reg(ADDR_PENDING, 16'h00fd);
    rd_reg(ADDR_PENDING, 16'h0022, 16'h0022);
    wr_reg(ADDR_ENABLE, 16'h0021);
    exp_pc.push_back(vecw(RANK_NMI));
    core_pulse(0, 16'h1234);
    settle();
    rd_reg(ADDR_SP, 16'hffff, 16'h0002);
    rd_reg(ADDR_STATUS, 16'h0001, 16'h0001);
    rd_reg(ADDR_ENABLE, 16'h0001, 16'h0000);
    rd_reg(ADDR_PENDING, 16'h0022, 16'h0020);
    core_pulse(0, 16'h1300);
    cyc(10);
    exp_pc.push_back(16'h1234);
    core_pulse(1, 16'h0000);
    settle();
    rd_reg(ADDR_ENABLE, 16'h0001, 16'h0001);
    $display("test acknowledge done");
    exp_pc.push_back(vecw(RANK_TIMER));
    core_pulse(0, 16'h2222);
    settle();
    rd_reg(ADDR_PENDING, 16'h0020, 16'h0020);
    wr_reg(ADDR_ENABLE, 16'h0005);
    exp_pc.push_back(vecw(RANK_EDGE_A));
    core_pulse(0, 16'h3333);
    settle();
    rd_reg(ADDR_PENDING, 16'h0004, 16'h0000);
    exp_pc.push_back(16'h3333);
    core_pulse(2, 16'h0000);
    settle();
    exp_pc.push_back(16'h2222);
    core_pulse(2, 16'h0000);
    settle();
    rd_reg(ADDR_ENABLE, 16'h0001, 16'h0000);
    rd_reg(ADDR_SP, 16'hffff, 16'h0000);
    $display("test nesting done");
    wr_reg(ADDR_ENABLE, 16'h0041);
    {i_uart_rx_req, i_uart_tx_req} <= 2'b11;
    i_shared_lowlevel_irq_pin_n <= 1'b0;
    cyc(6);
    exp_pc.push_back(vecw(RANK_SHARED));
    core_pulse(0, 16'h4444);
    settle();
    rd_reg(ADDR_PENDING, 16'h0040, 16'h0040);
    i_shared_lowlevel_irq_pin_n <= 1'b1;
    {i_uart_rx_req, i_uart_tx_req} <= 2'b00;
    exp_pc.push_back(16'h4444);
    core_pulse(2, 16'h0000);
    settle();
    wr_reg(ADDR_PENDING, 16'h00bf);
    rd_reg(ADDR_PENDING, 16'h0040, 16'h0000);
    wr_reg(ADDR_UART, 16'h0001);
    i_uart_rx_req <= 1'b1;
    cyc(2);
    rd_reg(ADDR_PENDING, 16'h0040, 16'h0040);
    i_uart_rx_req <= 1'b0;
    $display("test shared pin done");
    @(posedge i_core_clk) i_reset_pin_n <= 1'b0;
    cyc(4);
    exp_pc.push_back(vecw(RANK_RESET));
    i_reset_pin_n <= 1'b1;
    settle();
    $display("test reset pin done");
    end_sim();
  end
endmodule

// file: viu_mem_model.sv
// memory partner of the unit: stack words and vector bytes, prompt or slow acknowledge
`timescale 1ns/1ps
module viu_mem_model
  import viu_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_slow,
  output logic             o_ack,
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [logic [15:0]];
  logic [2:0] wait_cnt;

  ////////////////////////////////////////////////////////////
  initial
  begin
    o_ack = 1'b0;
    o_rdata = 8'h00;
    wait_cnt = 3'h0;
    for (int r = 0; r < NSRC; r++)
    begin
      mem[16'(VEC_TOP - VEC_STEP * 16'(r))] = 8'h10 + 8'(r);
      mem[16'(VEC_TOP - VEC_STEP * 16'(r) + 16'h0001)] = 8'h80 + 8'(r);
    end
  end

  ////////////////////////////////////////////////////////////
  // slow mode waits four extra cycles so the unit's held request is exercised
  always @(posedge i_core_clk)
  begin
    if (i_req && !o_ack && wait_cnt >= (i_slow ? 3'h4 : 3'h0))
    begin
      o_ack <= 1'b1;
      wait_cnt <= 3'h0;
      if (i_we)
      begin
        mem[i_addr] = i_wdata[7:0];
        mem[i_addr + 16'h0001] = i_wdata[15:8];
      end
      o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 8'h5a;
    end
    else
    begin
      o_ack <= 1'b0;
      wait_cnt <= (i_req && !o_ack) ? wait_cnt + 3'h1 : 3'h0;
      // data released outside the ack cycle: never leave the last byte standing
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// file: viu_pkg.sv
// constants, field positions, register offsets and state codes of the vectored interrupt unit
package viu_pkg;

  localparam int          NSRC          = 8;
  localparam int          NPIN          = 7;
  localparam int          NEDGE         = 3;

  // source ranks, also bit positions in the pending register and, from rank 2 up, in the enable register
  localparam int          RANK_RESET    = 0;
  localparam int          RANK_NMI      = 1;
  localparam int          RANK_EDGE_A   = 2;
  localparam int          RANK_TIMER    = 5;
  localparam int          RANK_SHARED   = 6;
  localparam int          RANK_CAPTURE  = 7;

  // pin vector positions after synchronisation
  localparam int          PIN_RESET_N   = 0;
  localparam int          PIN_NMI       = 1;
  localparam int          PIN_EDGE_A    = 2;
  localparam int          PIN_SHARED_N  = 5;
  localparam int          PIN_CAPTURE   = 6;
  localparam logic [6:0]  PIN_IDLE      = 7'h21;

  // vector words: rank 0 at the top pair, each further rank one pair lower
  localparam logic [15:0] VEC_TOP       = 16'hfffe;
  localparam logic [15:0] VEC_STEP      = 16'h0002;
  localparam logic [15:0] SP_STEP       = 16'h0002;
  localparam logic [15:0] SP_RESET      = 16'h0000;

  // register offsets on the plain register port
  localparam logic [7:0]  ADDR_ENABLE   = 8'h00;
  localparam logic [7:0]  ADDR_PENDING  = 8'h04;
  localparam logic [7:0]  ADDR_POLARITY = 8'h08;
  localparam logic [7:0]  ADDR_CAPTURE  = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;
  localparam logic [7:0]  ADDR_SP       = 8'h14;
  localparam logic [7:0]  ADDR_UART     = 8'h18;
  localparam logic [7:0]  ADDR_STATE    = 8'h1c;

  localparam int          GIE_BIT       = 0;
  localparam int          SAVED_BIT     = 0;
  localparam int          UART_RX_BIT   = 0;
  localparam int          UART_TX_BIT   = 1;
  localparam logic [7:0]  PEND_RO_MASK  = 8'h03;
  localparam logic [7:0]  HW_CLR_MASK   = 8'hdf;

  typedef enum logic [1:0] {
    CAP_RISE = 2'b00,
    CAP_FALL = 2'b01,
    CAP_HIGH = 2'b10,
    CAP_LOW  = 2'b11
  } viu_cap_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RST_WAIT = 3'b001,
    ST_PUSH     = 3'b010,
    ST_VEC_LO   = 3'b011,
    ST_VEC_HI   = 3'b100,
    ST_POP_LO   = 3'b101,
    ST_POP_HI   = 3'b110
  } viu_state_t;

endpackage

// file: viu_unit.sv
// vectored interrupt unit: pin capture, pending flags, ranking and acknowledge sequencer
`timescale 1ns/1ps
module viu_unit
  import viu_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_nonmaskable_pin,
  input  wire logic        i_edge_irq_pin_a,
  input  wire logic        i_edge_irq_pin_b,
  input  wire logic        i_edge_irq_pin_c,
  input  wire logic        i_shared_lowlevel_irq_pin_n,
  input  wire logic        i_capture_irq_pin,
  input  wire logic        i_timer_ovf,
  input  wire logic        i_uart_rx_req,
  input  wire logic        i_uart_tx_req,
  input  wire logic        i_instr_done,
  input  wire logic        i_return_from_irq,
  input  wire logic        i_ret,
  input  wire logic [15:0] i_pc,
  input  wire logic        i_mem_ack,
  input  wire logic [7:0]  i_mem_rdata,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rd_data,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic             o_mem_byte,
  output logic [15:0]      o_mem_addr,
  output logic [15:0]      o_mem_wdata,
  output logic             o_pc_load,
  output logic [15:0]      o_new_pc,
  output logic             o_core_hold
);

  ////////////////////////////////////////////////////////////////////////////
  logic [6:0]    pin_meta;
  logic [6:0]    pin_sync;
  logic [6:0]    pin_prev;
  logic [6:0]    pin_raw;
  logic [7:0]    pending;
  logic [7:0]    enable_mask;
  logic          global_irq_enable;
  logic          saved_global_enable;
  logic [2:0]    irq_polarity_ctrl;
  viu_cap_mode_t capture_mode;
  logic [1:0]    uart_irq_ctrl;
  logic [15:0]   sp;
  viu_state_t    state;
  logic [2:0]    sel;
  logic          ret_is_return_from_irq;
  logic [7:0]    lo_byte;
  logic [7:0]    set_vec;
  logic [7:0]    allowed;
  logic [7:0]    req;
  logic [2:0]    next_sel;
  logic          any_req;
  logic          rst_req;
  logic          cap_hit;
  logic          start_ack;
  logic          start_pop;
  logic          serviced;
  logic          pop_done;
  logic [2:0]    edge_hit;

  assign pin_raw = {i_capture_irq_pin, i_shared_lowlevel_irq_pin_n, i_edge_irq_pin_c,
                    i_edge_irq_pin_b, i_edge_irq_pin_a, i_nonmaskable_pin, i_reset_pin_n};

  // two stages before any logic; pin_prev follows the second stage only
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger conditions
  genvar g;
  generate
    for (g = 0; g < NEDGE; g++)
    begin : g_edge
      // polarity one selects the rising edge
      assign edge_hit[g] = irq_polarity_ctrl[g] ?
                           (pin_sync[PIN_EDGE_A+g] & ~pin_prev[PIN_EDGE_A+g]) :
                           (~pin_sync[PIN_EDGE_A+g] & pin_prev[PIN_EDGE_A+g]);
    end
  endgenerate

  always_comb
  begin
    case (capture_mode)
      CAP_RISE: cap_hit = pin_sync[PIN_CAPTURE] & ~pin_prev[PIN_CAPTURE];
      CAP_FALL: cap_hit = ~pin_sync[PIN_CAPTURE] & pin_prev[PIN_CAPTURE];
      CAP_HIGH: cap_hit = pin_sync[PIN_CAPTURE];
      CAP_LOW:  cap_hit = ~pin_sync[PIN_CAPTURE];
      default:  cap_hit = 1'b0;
    endcase
  end

  assign rst_req = ~pin_sync[PIN_RESET_N];
  always_comb
  begin
    set_vec               = 8'h00;
    set_vec[RANK_RESET]   = rst_req;
    set_vec[RANK_NMI]     = pin_sync[PIN_NMI] & ~pin_prev[PIN_NMI];
    set_vec[4:2]          = edge_hit;
    set_vec[RANK_TIMER]   = i_timer_ovf;
    // the shared vector serves the low pin and each uart request whose enable bit is set
    set_vec[RANK_SHARED]  = ~pin_sync[PIN_SHARED_N]
                          | (i_uart_rx_req & uart_irq_ctrl[UART_RX_BIT])
                          | (i_uart_tx_req & uart_irq_ctrl[UART_TX_BIT]);
    set_vec[RANK_CAPTURE] = cap_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // masking and ranking
  always_comb
  begin
    allowed             = enable_mask & {8{global_irq_enable}};
    allowed[RANK_NMI]   = 1'b1;
    allowed[RANK_RESET] = 1'b0;
    req                 = pending & allowed;
    any_req             = |req;
    next_sel            = 3'd0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        next_sel = 3'(i);
      end
    end
  end

  assign start_ack = (state == ST_IDLE) && !rst_req && i_instr_done && any_req;
  assign start_pop = (state == ST_IDLE) && !rst_req && !start_ack && (i_return_from_irq || i_ret);
  assign serviced  = (state == ST_PUSH) && i_mem_ack && !rst_req;
  assign pop_done  = (state == ST_POP_HI) && i_mem_ack && !rst_req;

  ////////////////////////////////////////////////////////////////////////////
  // pending flags: hardware set always beats any clear in the same cycle
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pending <= 8'h00;
    end
    else
    begin
      pending <= (pending
                 & ((i_wr && i_addr == ADDR_PENDING) ?
                    (i_wr_data[7:0] | PEND_RO_MASK) : 8'hff)
                 & ~((serviced ? 8'(8'h01 << sel) : 8'h00) & HW_CLR_MASK)
                 & ~((state == ST_VEC_HI && i_mem_ack && sel == 3'd0) ? 8'h01 : 8'h00))
                 | set_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers written by software
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      enable_mask       <= 8'h00;
      irq_polarity_ctrl <= 3'h0;
      capture_mode      <= CAP_RISE;
      uart_irq_ctrl     <= 2'h0;
    end
    else if (i_wr)
    begin
      case (i_addr)
        ADDR_ENABLE:   enable_mask       <= {i_wr_data[7:2], 2'b00};
        ADDR_POLARITY: irq_polarity_ctrl <= i_wr_data[2:0];
        ADDR_CAPTURE:  capture_mode      <= viu_cap_mode_t'(i_wr_data[1:0]);
        ADDR_UART:     uart_irq_ctrl     <= i_wr_data[1:0];
        default:       enable_mask       <= enable_mask;
      endcase
    end
  end

  // global enable and its saved copy in the status word
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      global_irq_enable   <= 1'b0;
      saved_global_enable <= 1'b0;
    end
    else if (rst_req)
    begin
      global_irq_enable   <= 1'b0;
      saved_global_enable <= 1'b0;
    end
    else if (start_ack)
    begin
      saved_global_enable <= global_irq_enable;
      global_irq_enable   <= 1'b0;
    end
    else if (pop_done)
    begin
      if (ret_is_return_from_irq && saved_global_enable)
      begin
        global_irq_enable <= 1'b1;
      end
    end
    else if (i_wr && i_addr == ADDR_ENABLE)
    begin
      global_irq_enable <= i_wr_data[GIE_BIT];
    end
    else if (i_wr && i_addr == ADDR_STATUS)
    begin
      saved_global_enable <= i_wr_data[SAVED_BIT];
    end
  end

  // stack pointer: word stack growing upward by two bytes per push
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sp <= SP_RESET;
    end
    else if (serviced)
    begin
      sp <= sp + SP_STEP;
    end
    else if (pop_done)
    begin
      sp <= sp - SP_STEP;
    end
    else if (i_wr && i_addr == ADDR_SP)
    begin
      sp <= i_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge and return sequencer; reset pin aborts anything in flight
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state       <= ST_RST_WAIT;
      sel         <= 3'd0;
      ret_is_return_from_irq <= 1'b0;
      lo_byte     <= 8'h00;
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_byte  <= 1'b0;
      o_mem_addr  <= 16'h0000;
      o_mem_wdata <= 16'h0000;
      o_pc_load   <= 1'b0;
      o_new_pc    <= 16'h0000;
      o_core_hold <= 1'b1;
    end
    else
    begin
      o_pc_load <= 1'b0;
      if (rst_req)
      begin
        state       <= ST_RST_WAIT;
        o_mem_req   <= 1'b0;
        o_core_hold <= 1'b1;
      end
      else
      begin
        case (state)
          ST_RST_WAIT:
          begin
            state      <= ST_VEC_LO;
            sel        <= 3'd0;
            o_mem_req  <= 1'b1;
            o_mem_we   <= 1'b0;
            o_mem_byte <= 1'b1;
            o_mem_addr <= VEC_TOP;
          end
          ST_IDLE:
          begin
            if (start_ack)
            begin
              state       <= ST_PUSH;
              sel         <= next_sel;
              o_mem_req   <= 1'b1;
              o_mem_we    <= 1'b1;
              o_mem_byte  <= 1'b0;
              o_mem_addr  <= sp;
              o_mem_wdata <= i_pc;
              o_core_hold <= 1'b1;
            end
            else if (start_pop)
            begin
              state       <= ST_POP_LO;
              ret_is_return_from_irq <= i_return_from_irq;
              o_mem_req   <= 1'b1;
              o_mem_we    <= 1'b0;
              o_mem_byte  <= 1'b1;
              o_mem_addr  <= sp - SP_STEP;
              o_core_hold <= 1'b1;
            end
          end
          ST_PUSH:
          begin
            if (i_mem_ack)
            begin
              state      <= ST_VEC_LO;
              o_mem_we   <= 1'b0;
              o_mem_byte <= 1'b1;
              o_mem_addr <= VEC_TOP - 16'(VEC_STEP * sel);
            end
          end
          ST_VEC_LO, ST_POP_LO:
          begin
            if (i_mem_ack)
            begin
              state      <= (state == ST_VEC_LO) ? ST_VEC_HI : ST_POP_HI;
              lo_byte    <= i_mem_rdata;
              o_mem_addr <= o_mem_addr + 16'h0001;
            end
          end
          ST_VEC_HI, ST_POP_HI:
          begin
            if (i_mem_ack)
            begin
              state       <= ST_IDLE;
              o_mem_req   <= 1'b0;
              o_pc_load   <= 1'b1;
              o_new_pc    <= {i_mem_rdata, lo_byte};
              o_core_hold <= 1'b0;
            end
          end
          default:
          begin
            state     <= ST_IDLE;
            o_mem_req <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data in the cycle after the strobe
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_rd_data <= 16'h0000;
    end
    else if (i_rd)
    begin
      case (i_addr)
        ADDR_ENABLE:   o_rd_data <= {8'h00, enable_mask[7:2], 1'b0, global_irq_enable};
        ADDR_PENDING:  o_rd_data <= {8'h00, pending};
        ADDR_POLARITY: o_rd_data <= {13'h0000, irq_polarity_ctrl};
        ADDR_CAPTURE:  o_rd_data <= {14'h0000, capture_mode};
        ADDR_STATUS:   o_rd_data <= {15'h0000, saved_global_enable};
        ADDR_SP:       o_rd_data <= sp;
        ADDR_UART:     o_rd_data <= {14'h0000, uart_irq_ctrl};
        ADDR_STATE:    o_rd_data <= {10'h000, sel, state};
        default:       o_rd_data <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_ack_start;
    state == ST_IDLE && !rst_req && i_instr_done && any_req;
  endsequence

  sequence s_return_from_irq_end;
    state == ST_POP_HI && i_mem_ack && !rst_req && ret_is_return_from_irq && saved_global_enable;
  endsequence

  property p_push_sp;
    @(posedge i_core_clk) disable iff (i_reset)
    serviced |=> sp == $past(sp) + SP_STEP;
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("sp not advanced by two");

  property p_gie_save;
    @(posedge i_core_clk) disable iff (i_reset)
    s_ack_start |=> !global_irq_enable && saved_global_enable == $past(global_irq_enable);
  endproperty
  a_gie_save: assert property (p_gie_save) else $error("enable not saved");

  property p_vec_addr;
    @(posedge i_core_clk) disable iff (i_reset)
    serviced |=> o_mem_addr == {12'hfff, ~sel, 1'b0} && o_mem_byte;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("wrong vector address");

  property p_prio;
    @(posedge i_core_clk) disable iff (i_reset)
    s_ack_start |=> (($past(req) & 8'((8'h01 << sel) - 8'h01)) == 8'h00)
      && (($past(req) & 8'(8'h01 << sel)) != 8'h00);
  endproperty
  a_prio: assert property (p_prio) else $error("lower rank skipped");

  property p_mask;
    @(posedge i_core_clk) disable iff (i_reset)
    s_ack_start |=> sel == 3'd1
      || ($past(global_irq_enable) && (($past(enable_mask) & 8'(8'h01 << sel)) != 8'h00));
  endproperty
  a_mask: assert property (p_mask) else $error("masked source taken");

  property p_wait_instr;
    @(posedge i_core_clk) disable iff (i_reset)
    state == ST_IDLE && !rst_req && !i_instr_done && !i_return_from_irq && !i_ret |=> state == ST_IDLE;
  endproperty
  a_wait_instr: assert property (p_wait_instr) else $error("taken mid instruction");

  property p_rst_now;
    @(posedge i_core_clk) disable iff (i_reset)
    rst_req |=> state == ST_RST_WAIT && !o_mem_req ##1 o_core_hold;
  endproperty
  a_rst_now: assert property (p_rst_now) else $error("reset not immediate");

  property p_return_from_irq;
    @(posedge i_core_clk) disable iff (i_reset)
    s_return_from_irq_end |=> global_irq_enable && o_pc_load;
  endproperty
  a_return_from_irq: assert property (p_return_from_irq) else $error("return_from_irq did not restore enable");

  property p_load_pc;
    @(posedge i_core_clk) disable iff (i_reset)
    state == ST_VEC_HI && i_mem_ack && !rst_req
      |=> o_pc_load && o_new_pc[15:8] == $past(i_mem_rdata) && $past(o_mem_addr[0]);
  endproperty
  a_load_pc: assert property (p_load_pc) else $error("vector bytes misplaced");

  property p_nmi_ro;
    @(posedge i_core_clk) disable iff (i_reset)
    i_wr && i_addr == ADDR_PENDING && !serviced |=> pending[1] == $past(pending[1]) | $past(set_vec[1]);
  endproperty
  a_nmi_ro: assert property (p_nmi_ro) else $error("nmi flag written");

endmodule
